// [pkg/rsc_clear_if.sv]
// Bundle of per-group clear requests passed from the cause decoder to the pulse stretcher.
// Assumes both ends run on the same clock.
interface rsc_clear_if;
   logic aon;
   logic regs;
   logic seq;
   logic [6:0] dsp;
   modport src (output aon, output regs, output seq, output dsp);
   modport dst (input aon, input regs, input seq, input dsp);
endinterface : rsc_clear_if

// [pkg/rsc_pkg.sv]
// Package for the reset scope controller: storage groups, reset causes and timing constants.
// Assumes a single 250 MHz clock domain and supply monitor levels already synchronous to it.
package rsc_pkg;
   localparam int RSC_NUM_DSP = 7;
   localparam int RSC_RETAIN_DSP_IDX = 5;
   localparam logic [6:0] RSC_DSP_ALL = 7'h7F;
   localparam logic [6:0] RSC_DSP_HW_MASK = 7'h5F;
   localparam logic [3:0] RSC_RESET_ADDR = 4'h0;
   localparam int RSC_CLK_PERIOD_NS = 4;
   localparam int RSC_SYNC_STAGES = 2;
   localparam int RSC_PULSE_NS = 16;
   localparam int RSC_PULSE_CYC = (RSC_PULSE_NS + RSC_CLK_PERIOD_NS - 1) / RSC_CLK_PERIOD_NS;
   localparam logic [2:0] RSC_PULSE_CYC_W = 3'(RSC_PULSE_CYC);
   localparam logic [2:0] RSC_CNT_RESET = 3'h0;
   typedef enum logic [1:0] {RSC_RUN, RSC_SLEEP} rsc_pwr_t;
endpackage : rsc_pkg

// [sim/rsc_host_model.sv]
// Host model: drives the supply monitors, the reset pin, the regulator enable and register writes.
// Assumes a rising-edge device; every change lands on the falling edge.
module rsc_host_model (
   input wire logic clk,
   output logic analog_supply_ok,
   output logic io_supply_one_ok,
   output logic regulator_input_supply_ok,
   output logic core_supply_ok,
   output logic regulator_enable_pin,
   output logic hw_reset_n,
   output logic reg_wr_en,
   output logic [3:0] reg_wr_addr
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      {analog_supply_ok, io_supply_one_ok, regulator_input_supply_ok, core_supply_ok} = 4'hF;
      regulator_enable_pin = 1'b1;
      hw_reset_n = 1'b1;
      reg_wr_en = 1'b0;
      reg_wr_addr = 4'h0;
   end
   task automatic write_reg(input logic [3:0] a);
      @(negedge clk);
      reg_wr_en = 1'b1;
      reg_wr_addr = a;
      @(negedge clk);
      reg_wr_en = 1'b0;
      // Idle index lines show the inverse, so a stale index is never taken for a live one.
      reg_wr_addr = ~a;
   endtask : write_reg
   task automatic hw(input logic on);
      @(negedge clk);
      regulator_enable_pin = 1'b1;
      hw_reset_n = ~on;
   endtask : hw
   task automatic sleep(input logic on);
      @(negedge clk);
      regulator_enable_pin = ~on;
      core_supply_ok = ~on;
   endtask : sleep
   // Only used when the bench deliberately drops the core supply inside a reset.
   task automatic core(input logic v);
      @(negedge clk);
      core_supply_ok = v;
   endtask : core
   // A missing regulator input must keep the device out of sleep.
   task automatic reg_input(input logic v);
      @(negedge clk);
      regulator_input_supply_ok = v;
   endtask : reg_input
   task automatic supply(input logic a, input logic i);
      @(negedge clk);
      analog_supply_ok = a;
      io_supply_one_ok = i;
   endtask : supply
endmodule : rsc_host_model

// [sim/tb_top.sv]
// Self-checking bench for the reset scope controller.
// Assumes the host model owns every cause input; the bench only owns clock and reset.
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import rsc_pkg::*;
   logic clk, rst_n, an, io, ri, co, en, hw_n, we, ca, cr, cs, pa, sa;
   logic [3:0] wa;
   logic [6:0] cd;
   int error_cnt = 0;
   int checks_done = 0;
   rsc_host_model u_host (.clk(clk), .analog_supply_ok(an), .io_supply_one_ok(io),
      .regulator_input_supply_ok(ri), .core_supply_ok(co), .regulator_enable_pin(en),
      .hw_reset_n(hw_n), .reg_wr_en(we), .reg_wr_addr(wa));
   rsc_top u_dut (.clk(clk), .rst_n(rst_n), .analog_supply_ok(an), .io_supply_one_ok(io),
      .regulator_input_supply_ok(ri), .core_supply_ok(co), .regulator_enable_pin(en),
      .hw_reset_n(hw_n), .reg_wr_en(we), .reg_wr_addr(wa), .clr_aon(ca), .clr_regs(cr),
      .clr_seq(cs), .clr_dsp(cd), .por_active(pa), .sleep_active(sa));
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   task automatic summarize();
      $display("checks %0d mismatches %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : summarize
   // Outputs packed as por, sleep, aon, regs, seq, dsp[6:0], sampled after n falling edges.
   task automatic chk(input string what, input int n, input logic [11:0] exp);
      logic [11:0] seen;
      repeat (n) @(negedge clk);
      seen = {pa, sa, ca, cr, cs, cd};
      checks_done++;
      if (seen !== exp) begin
         error_cnt++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   task automatic t_soft();
      u_host.write_reg(4'h3);
      chk("other index", 3, 12'h000);
      u_host.write_reg(RSC_RESET_ADDR);
      chk("soft clear", 2, 12'h300);
      chk("soft release", 5, 12'h000);
      $display("test soft reset done");
   endtask : t_soft
   task automatic t_hard();
      u_host.hw(1'b1);
      chk("hard clear", 3, 12'h3DF);
      u_host.core(1'b0);
      chk("hard core lost", 2, 12'h3FF);
      u_host.core(1'b1);
      u_host.hw(1'b0);
      chk("hard release", 10, 12'h000);
      $display("test hardware reset done");
   endtask : t_hard
   task automatic t_por();
      for (int k = 0; k < 2; k++) begin
         u_host.supply(k[0], ~k[0]);
         chk("por hold", 3, 12'hBFF);
         u_host.supply(1'b1, 1'b1);
         chk("por release", 12, 12'h000);
      end
      $display("test power-on reset done");
   endtask : t_por
   task automatic t_sleep();
      u_host.sleep(1'b1);
      chk("sleep entry", 3, 12'h5FF);
      // The core supply is down in sleep, so this write also clears all firmware.
      u_host.write_reg(RSC_RESET_ADDR);
      chk("sleep plus soft", 2, 12'h77F);
      chk("sleep keeps aon", 6, 12'h500);
      u_host.sleep(1'b0);
      chk("sleep exit", 12, 12'h000);
      u_host.reg_input(1'b0);
      u_host.sleep(1'b1);
      chk("no sleep without input", 3, 12'h000);
      fork
         u_host.reg_input(1'b1);
         u_host.write_reg(RSC_RESET_ADDR);
      join
      chk("soft at sleep entry", 2, 12'h7FF);
      u_host.sleep(1'b0);
      chk("second sleep exit", 12, 12'h000);
      $display("test sleep done");
   endtask : t_sleep
   initial begin
      rst_n = 1'b0;
      repeat (2) @(negedge clk);
      chk("in reset", 0, 12'hBFF);
      rst_n = 1'b1;
      chk("after reset", 12, 12'h000);
      t_soft();
      t_hard();
      t_por();
      t_sleep();
      summarize();
   end
   // The tests take roughly 130 cycles; a generous margin covers slow stretching.
   initial begin
      #(RSC_CLK_PERIOD_NS * 2000);
      error_cnt++;
      summarize();
   end
endmodule : tb_top

// [src/rsc_stretch.sv]
// Pulse stretcher: holds each group clear for a minimum number of cycles after its request ends.
// Assumes requests come from the main controller on the same clock and reset.
module rsc_stretch
   import rsc_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   rsc_clear_if.dst req,
   output logic clr_aon,
   output logic clr_regs,
   output logic clr_seq,
   output logic [6:0] clr_dsp
);
   logic [9:0] req_vec;
   logic [2:0] cnt_r [10];
   logic [9:0] out_r;
   assign req_vec = {req.aon, req.regs, req.seq, req.dsp};
   // Stretching keeps a one-cycle register write from giving storage too short a clear.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < 10; i++) begin
            cnt_r[i] <= RSC_CNT_RESET;
         end
         out_r <= 10'h3FF;
      end else begin
         for (int i = 0; i < 10; i++) begin
            if (req_vec[i]) begin
               cnt_r[i] <= RSC_PULSE_CYC_W;
               out_r[i] <= 1'b1;
            end else if (cnt_r[i] != RSC_CNT_RESET) begin
               cnt_r[i] <= cnt_r[i] - 3'h1;
               out_r[i] <= 1'b1;
            end else begin
               out_r[i] <= 1'b0;
            end
         end
      end
   end
   assign {clr_aon, clr_regs, clr_seq, clr_dsp} = out_r;
   stretch_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
      $fell(req_vec[9]) |-> out_r[9] [*4]) else $error("aon clear shorter than minimum");
endmodule : rsc_stretch

// [src/rsc_top.sv]
// Reset scope controller: decides which storage groups clear under each reset condition.
// Assumes supply-good levels and the write strobe are synchronous to clk; reset pin is active low.
// Summary of operation
// - Power-on reset holds while analog or first I/O supply is below threshold.
// - Hardware reset whenever the external reset pin is low.
// - Any write to register index 0 triggers software reset, data ignored.
// - Disabling core regulator enters sleep; needs analog, I/O, regulator input supplies.
// - Power-on reset clears always-on, other registers, sequencer, all DSP firmware.
// - Hardware reset clears registers, sequencer, DSP 1-5 and 7; keeps DSP 6.
// - Software reset clears all registers, keeps sequencer and all DSP firmware.
// - Sleep keeps always-on registers, clears other registers, sequencer, all firmware.
// - Firmware survives hardware or software reset only if core supply stays up.
module rsc_top
   import rsc_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic analog_supply_ok,
   input wire logic io_supply_one_ok,
   input wire logic regulator_input_supply_ok,
   input wire logic core_supply_ok,
   input wire logic regulator_enable_pin,
   input wire logic hw_reset_n,
   input wire logic reg_wr_en,
   input wire logic [3:0] reg_wr_addr,
   output logic clr_aon,
   output logic clr_regs,
   output logic clr_seq,
   output logic [6:0] clr_dsp,
   output logic por_active,
   output logic sleep_active
);
   import rsc_pkg::*;

   logic [1:0] rst_sync_r;
   logic srst_n;
   logic por;
   logic hw;
   logic sw;
   logic core_lost_r;
   logic core_lost_nxt;
   rsc_pwr_t pwr_r;
   rsc_pwr_t pwr_nxt;
   logic sleep_entry;
   rsc_clear_if clr_bus ();

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rst_sync_r <= 2'h0;
      end else begin
         rst_sync_r <= {rst_sync_r[0], 1'b1};
      end
   end
   assign srst_n = rst_sync_r[1];

   assign por = !analog_supply_ok || !io_supply_one_ok;
   assign hw = !hw_reset_n;
   assign sw = reg_wr_en && (reg_wr_addr == RSC_RESET_ADDR);

   always_comb begin
      pwr_nxt = pwr_r;
      case (pwr_r)
         RSC_RUN: begin
            if (!regulator_enable_pin && !por && regulator_input_supply_ok) begin
               pwr_nxt = RSC_SLEEP;
            end
         end
         RSC_SLEEP: begin
            if (regulator_enable_pin || por || !regulator_input_supply_ok) begin
               pwr_nxt = RSC_RUN;
            end
         end
         default: pwr_nxt = RSC_RUN;
      endcase
   end

   always_ff @(posedge clk or negedge srst_n) begin
      if (!srst_n) begin
         pwr_r <= RSC_RUN;
      end else begin
         pwr_r <= pwr_nxt;
      end
   end
   assign sleep_entry = (pwr_r == RSC_RUN) && (pwr_nxt == RSC_SLEEP);

   // track core supply loss during a reset
   always_comb begin
      core_lost_nxt = core_lost_r;
      if (hw || sw) begin
         core_lost_nxt = core_lost_r || !core_supply_ok;
      end else begin
         core_lost_nxt = 1'b0;
      end
   end

   always_ff @(posedge clk or negedge srst_n) begin
      if (!srst_n) begin
         core_lost_r <= 1'b0;
      end else begin
         core_lost_r <= core_lost_nxt;
      end
   end

   // union of active conditions
   // Each cause only adds clears, so any overlap of causes yields the union of their actions.
   always_comb begin
      clr_bus.aon = 1'b0;
      clr_bus.regs = 1'b0;
      clr_bus.seq = 1'b0;
      clr_bus.dsp = 7'h00;
      if (por) begin
         clr_bus.aon = 1'b1;
         clr_bus.regs = 1'b1;
         clr_bus.seq = 1'b1;
         clr_bus.dsp = RSC_DSP_ALL;
      end
      if (hw) begin
         clr_bus.aon = 1'b1;
         clr_bus.regs = 1'b1;
         clr_bus.seq = 1'b1;
         clr_bus.dsp = clr_bus.dsp | RSC_DSP_HW_MASK;
      end
      if (sw) begin
         clr_bus.aon = 1'b1;
         clr_bus.regs = 1'b1;
      end
      if (sleep_entry) begin
         clr_bus.regs = 1'b1;
         clr_bus.seq = 1'b1;
         clr_bus.dsp = RSC_DSP_ALL;
      end
      // Other registers stay cleared for the whole stay in sleep.
      if (pwr_r == RSC_SLEEP) begin
         clr_bus.regs = 1'b1;
      end
      if (core_lost_nxt) begin
         clr_bus.dsp = RSC_DSP_ALL;
      end
   end

   rsc_stretch u_stretch (
      .clk(clk),
      .rst_n(srst_n),
      .req(clr_bus),
      .clr_aon(clr_aon),
      .clr_regs(clr_regs),
      .clr_seq(clr_seq),
      .clr_dsp(clr_dsp)
   );

   // Status outputs are registered so the host sees glitch-free levels.
   always_ff @(posedge clk or negedge srst_n) begin
      if (!srst_n) begin
         por_active <= 1'b1;
         sleep_active <= 1'b0;
      end else begin
         por_active <= por;
         sleep_active <= (pwr_nxt == RSC_SLEEP);
      end
   end

   por_clear_a: assert property (@(posedge clk) disable iff (!srst_n)
      por |=> clr_aon && clr_regs && clr_seq && (clr_dsp == RSC_DSP_ALL)) else $error("power-on clear incomplete");
   hw_clear_a: assert property (@(posedge clk) disable iff (!srst_n)
      hw && !por && core_supply_ok |=> clr_regs && clr_seq && ((clr_dsp & RSC_DSP_HW_MASK) == RSC_DSP_HW_MASK))
      else $error("hardware reset clear incomplete");
   hw_keep_dsp_a: assert property (@(posedge clk) disable iff (!srst_n)
      !por && !sleep_entry && !core_lost_nxt && (pwr_r == RSC_RUN) [*6] |-> !clr_dsp[RSC_RETAIN_DSP_IDX])
      else $error("retained firmware cleared");
   sw_clear_a: assert property (@(posedge clk) disable iff (!srst_n)
      sw |=> clr_aon && clr_regs) else $error("software reset missed");
   sw_keep_seq_a: assert property (@(posedge clk) disable iff (!srst_n)
      (!por && !hw && !sleep_entry) [*6] |-> !clr_seq) else $error("sequencer cleared without cause");
   sleep_keep_a: assert property (@(posedge clk) disable iff (!srst_n)
      (pwr_r == RSC_SLEEP) |-> clr_regs && !sleep_entry) else $error("other registers not held cleared in sleep");
   sleep_aon_a: assert property (@(posedge clk) disable iff (!srst_n)
      (!por && !hw && !sw) [*6] |-> !clr_aon) else $error("always-on cleared in sleep");
   sleep_enter_a: assert property (@(posedge clk) disable iff (!srst_n)
      sleep_entry |=> clr_seq && clr_regs && (clr_dsp == RSC_DSP_ALL) && (pwr_r == RSC_SLEEP))
      else $error("sleep entry clear missing");
   core_loss_a: assert property (@(posedge clk) disable iff (!srst_n)
      (hw || sw) && !core_supply_ok |=> clr_dsp == RSC_DSP_ALL) else $error("firmware kept after core loss");
   union_a: assert property (@(posedge clk) disable iff (!srst_n)
      sw && sleep_entry |=> clr_aon && clr_seq) else $error("union of clears broken");

   // Further clear and status checks; those on clr_bus catch a wrong clear before the stretcher can hide it.
   hw_aon_a: assert property (@(posedge clk) disable iff (!srst_n)
      hw |=> clr_aon) else $error("hardware reset kept always-on registers");
   hw_keep_req_a: assert property (@(posedge clk) disable iff (!srst_n)
      hw && !por && !sleep_entry && core_supply_ok && !core_lost_r |-> !clr_bus.dsp[RSC_RETAIN_DSP_IDX])
      else $error("hardware reset requested retained firmware clear");
   sw_keep_dsp_a: assert property (@(posedge clk) disable iff (!srst_n)
      sw && !hw && !por && !sleep_entry && core_supply_ok && !core_lost_r |-> clr_bus.dsp == 7'h00)
      else $error("software reset requested firmware clear");
   sleep_aon_req_a: assert property (@(posedge clk) disable iff (!srst_n)
      (pwr_r == RSC_SLEEP) && !por && !hw && !sw |-> !clr_bus.aon)
      else $error("always-on clear requested in sleep");
   por_status_a: assert property (@(posedge clk) disable iff (!srst_n)
      por |=> por_active) else $error("power-on status missing");
   sleep_status_a: assert property (@(posedge clk) disable iff (!srst_n)
      sleep_entry |=> sleep_active) else $error("sleep status missing");
   sleep_supply_a: assert property (@(posedge clk) disable iff (!srst_n)
      (pwr_r == RSC_RUN) && !regulator_input_supply_ok |=> (pwr_r == RSC_RUN))
      else $error("sleep entered without regulator input supply");
   sleep_exit_a: assert property (@(posedge clk) disable iff (!srst_n)
      (pwr_r == RSC_SLEEP) && regulator_enable_pin |=> !sleep_active)
      else $error("sleep held with regulator enabled");

   por_c: cover property (@(posedge clk) disable iff (!srst_n) $rose(por));
   hw_c: cover property (@(posedge clk) disable iff (!srst_n) $rose(hw) && core_supply_ok);
   sw_c: cover property (@(posedge clk) disable iff (!srst_n) sw);
   sleep_c: cover property (@(posedge clk) disable iff (!srst_n) sleep_entry);
   soft_sleep_c: cover property (@(posedge clk) disable iff (!srst_n) sw && sleep_entry);
endmodule : rsc_top
